// *** hw/deep_sleep_consts.vh ***
// Function
// - Config bit seven enables deep sleep watchdog
// - Watchdog ignores main watchdog enable state
// - Deep sleep entry restarts watchdog counter
// - Config bit four picks watchdog clock
// - Bits three to zero pick postscaler
// - Config bit five picks calendar clock
// - Device starts watchdog clock if off
// - Entry sets deep sleep flag; software clears
// - True power-on while awake resets all deep sleep logic
// - Wake-up clears the arm bit
// - Pin change in sleep sets bit 8
// - Fault in sleep sets bit 7
// - Watchdog timeout in sleep sets bit 4
// - Calendar alarm in sleep sets bit 3
// - Enabled asserted reset pin in sleep sets bit 2
// - Flags reset by outside power-on; setting the arm bit also clears the wake flags
`ifndef DEEP_SLEEP_CONSTS_VH
`define DEEP_SLEEP_CONSTS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_CONTROL 4'h0
`define ADDR_WAKE 4'h4
`define ADDR_RESET_CTRL 4'h8
`define ADDR_CONFIG 4'hC

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CFG_WD_EN 7
`define CFG_CAL_SEL 5
`define CFG_WD_SEL 4
`define CFG_PS_HI 3
`define CFG_PS_LO 0
`define CTL_ARM 15
`define CTL_RELEASE 0
`define RC_DSLEEP 10
`define RC_POR 0
`define WK_PIN 8
`define WK_FAULT 7
`define WK_WDT 4
`define WK_ALARM 3
`define WK_MRST 2
`define WK_POR 0
`define WK_MASK 16'h019D

// ----------------------------------------
// Reset values and answers
// ----------------------------------------
`define CFG_RESET 8'h8F
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define WD_MIN_TICKS 6'h06

`endif

// *** hw/deep_sleep_wake_control.v ***
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "deep_sleep_consts.vh"

module deep_sleep_wake_control #(
	parameter CFG_RESET_VAL = 8'h8F
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Power and core events
	input wire true_power_on,
	input wire sleep_instr,
	// Wake sources
	input wire pin_change_evt,
	input wire fault_evt,
	input wire alarm_evt,
	input wire master_reset_pin_en,
	input wire master_reset_pin_n,
	input wire supply_por_evt,
	// Oscillator ticks and status
	input wire secondary_oscillator_tick,
	input wire low_power_rc_osc_tick,
	input wire secondary_oscillator_on,
	input wire low_power_rc_osc_on,
	// Outputs
	output reg in_deep_sleep,
	output reg wake_pulse,
	output reg secondary_oscillator_req,
	output reg low_power_rc_osc_req,
	output reg calendar_clock_tick,
	output reg release_hold
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	localparam ST_RUN = 1'b0;
	localparam ST_SLEEP = 1'b1;

	reg state_ff;
	reg arm_ff;
	reg [15:0] wake_ff;
	reg dsleep_flag_ff;
	reg por_flag_ff;
	reg [7:0] cfg_ff;
	reg [35:0] wd_cnt_ff;
	reg aw_hold_ff, w_hold_ff;
	reg [3:0] aw_addr_ff;
	reg [31:0] w_data_ff;
	reg [3:0] w_strb_ff;

	// Full reset: aresetn or a true power-on outside deep sleep
	wire hard_rst = !aresetn || (true_power_on && state_ff == ST_RUN);

	wire wd_en = cfg_ff[`CFG_WD_EN];
	wire wd_sel = cfg_ff[`CFG_WD_SEL];
	wire [3:0] ps = cfg_ff[`CFG_PS_HI:`CFG_PS_LO];
	wire wd_tick = wd_sel ? secondary_oscillator_tick : low_power_rc_osc_tick;
	wire wd_clk_on = wd_sel ? secondary_oscillator_on : low_power_rc_osc_on;
	// Postscale: 6*2^(2*ps) ticks, from 6 ticks up to 6*2^30 ticks
	wire [35:0] wd_limit = {30'h0, `WD_MIN_TICKS} << {ps, 1'b0};
	wire wd_timeout = state_ff == ST_SLEEP && wd_en && wd_cnt_ff >= wd_limit;
	wire mrst_evt = master_reset_pin_en && !master_reset_pin_n;
	wire enter = state_ff == ST_RUN && sleep_instr && arm_ff;
	wire any_wake = pin_change_evt || fault_evt || alarm_evt || mrst_evt ||
		supply_por_evt || wd_timeout;
	wire leave = state_ff == ST_SLEEP && any_wake;

	// ----------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------
	assign s_axi_awready = !aw_hold_ff && !s_axi_bvalid;
	assign s_axi_wready = !w_hold_ff && !s_axi_bvalid;
	wire aw_have = aw_hold_ff || s_axi_awvalid;
	wire w_have = w_hold_ff || s_axi_wvalid;
	wire wr_go = aw_have && w_have && !s_axi_bvalid;
	wire [3:0] wr_addr = aw_hold_ff ? aw_addr_ff : s_axi_awaddr;
	wire [31:0] wr_data = w_hold_ff ? w_data_ff : s_axi_wdata;
	wire [3:0] wr_strb = w_hold_ff ? w_strb_ff : s_axi_wstrb;
	wire wr_lo = wr_strb[0];
	wire wr_hi = wr_strb[1];
	wire wr_ok = wr_addr == `ADDR_CONTROL || wr_addr == `ADDR_WAKE ||
		wr_addr == `ADDR_RESET_CTRL || wr_addr == `ADDR_CONFIG;
	wire wr_ctl = wr_go && wr_addr == `ADDR_CONTROL;
	wire wr_wake = wr_go && wr_addr == `ADDR_WAKE;
	wire wr_rc = wr_go && wr_addr == `ADDR_RESET_CTRL;
	wire wr_cfg = wr_go && wr_addr == `ADDR_CONFIG && wr_lo;
	wire arm_set = wr_ctl && wr_hi && wr_data[`CTL_ARM] && !arm_ff;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			aw_addr_ff <= 4'h0;
			w_data_ff <= 32'h0;
			w_strb_ff <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready && !wr_go) begin
				aw_hold_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready && !wr_go) begin
				w_hold_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_hold_ff <= 1'b0;
				w_hold_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	reg [31:0] rd_val;
	reg rd_ok;
	always @* begin
		rd_val = 32'h0;
		rd_ok = 1'b1;
		case (s_axi_araddr)
		`ADDR_CONTROL: begin
			rd_val[`CTL_ARM] = arm_ff;
			rd_val[`CTL_RELEASE] = release_hold;
		end
		`ADDR_WAKE: rd_val[15:0] = wake_ff;
		`ADDR_RESET_CTRL: begin
			rd_val[`RC_DSLEEP] = dsleep_flag_ff;
			rd_val[`RC_POR] = por_flag_ff;
		end
		`ADDR_CONFIG: rd_val[7:0] = cfg_ff;
		default: rd_ok = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Sleep sequencing and watchdog
	// ----------------------------------------
	always @(posedge aclk) begin
		if (hard_rst) begin
			state_ff <= ST_RUN;
			arm_ff <= 1'b0;
			release_hold <= 1'b0;
			wd_cnt_ff <= 36'h0;
			in_deep_sleep <= 1'b0;
			wake_pulse <= 1'b0;
			cfg_ff <= CFG_RESET_VAL;
		end else begin
			wake_pulse <= 1'b0;
			if (wr_cfg)
				cfg_ff <= wr_data[7:0];
			case (state_ff)
			ST_RUN: begin
				if (wr_ctl && wr_hi)
					arm_ff <= wr_data[`CTL_ARM];
				if (wr_ctl && wr_lo)
					release_hold <= wr_data[`CTL_RELEASE];
				if (enter) begin
					state_ff <= ST_SLEEP;
					in_deep_sleep <= 1'b1;
					wd_cnt_ff <= 36'h0;
				end
			end
			ST_SLEEP: begin
				if (wd_en && wd_tick)
					wd_cnt_ff <= wd_cnt_ff + 36'h1;
				if (leave) begin
					state_ff <= ST_RUN;
					in_deep_sleep <= 1'b0;
					arm_ff <= 1'b0;
					release_hold <= 1'b1;
					wake_pulse <= 1'b1;
				end
			end
			default: state_ff <= ST_RUN;
			endcase
		end
	end

	// ----------------------------------------
	// Oscillator requests and calendar clock
	// ----------------------------------------
	always @(posedge aclk) begin
		if (hard_rst) begin
			secondary_oscillator_req <= 1'b0;
			low_power_rc_osc_req <= 1'b0;
			calendar_clock_tick <= 1'b0;
		end else begin
			// Clock started by hardware; counting waits for its first tick
			if (state_ff == ST_SLEEP && wd_en && !wd_clk_on) begin
				secondary_oscillator_req <= wd_sel | secondary_oscillator_req;
				low_power_rc_osc_req <= !wd_sel | low_power_rc_osc_req;
			end else if (state_ff == ST_RUN) begin
				secondary_oscillator_req <= 1'b0;
				low_power_rc_osc_req <= 1'b0;
			end
			calendar_clock_tick <= cfg_ff[`CFG_CAL_SEL] ? secondary_oscillator_tick :
				low_power_rc_osc_tick;
		end
	end

	// ----------------------------------------
	// Status flags: hardware set beats software clear
	// ----------------------------------------
	reg [15:0] wake_set;
	always @* begin
		wake_set = 16'h0;
		wake_set[`WK_PIN] = in_deep_sleep && pin_change_evt;
		wake_set[`WK_FAULT] = in_deep_sleep && fault_evt;
		wake_set[`WK_WDT] = wd_timeout;
		wake_set[`WK_ALARM] = in_deep_sleep && alarm_evt;
		wake_set[`WK_MRST] = in_deep_sleep && mrst_evt;
		wake_set[`WK_POR] = supply_por_evt;
	end

	// ----------------------------------------
	// Wake-source flags, one slice per bit
	// ----------------------------------------
	// A true power-on while awake clears the flags but sets bit 0; one seen from sleep is ignored
	wire por_clear = true_power_on && state_ff == ST_RUN;
	// Unimplemented bits never set, so they always read back as zero
	wire [15:0] wake_keep = `WK_MASK;
	localparam LANE_BITS = 8;
	genvar gi;
	generate
	for (gi = 0; gi < 16; gi = gi + 1) begin : g_wake
		wire lane_wr = wr_wake && ((gi < LANE_BITS) ? wr_lo : wr_hi);
		wire set_bit = wake_set[gi] && wake_keep[gi];
		always @(posedge aclk) begin
			if (!aresetn) begin
				wake_ff[gi] <= 1'b0;
			end else if (por_clear) begin
				wake_ff[gi] <= (gi == `WK_POR);
			end else if (arm_set) begin
				wake_ff[gi] <= set_bit;
			end else if (lane_wr) begin
				// Writing zero clears, writing one keeps; a new event still wins
				wake_ff[gi] <= (wake_ff[gi] && wr_data[gi]) || set_bit;
			end else begin
				wake_ff[gi] <= wake_ff[gi] || set_bit;
			end
		end
	end
	endgenerate

	// Power-on flag survives a deep sleep exit; only aresetn or a true power-on while awake sets it again
	always @(posedge aclk) begin
		if (!aresetn) begin
			por_flag_ff <= 1'b1;
			dsleep_flag_ff <= 1'b0;
		end else if (por_clear) begin
			por_flag_ff <= 1'b1;
			dsleep_flag_ff <= 1'b0;
		end else begin
			if (enter)
				dsleep_flag_ff <= 1'b1;
			else if (wr_rc && wr_hi && !wr_data[`RC_DSLEEP])
				dsleep_flag_ff <= 1'b0;
			if (wr_rc && wr_lo && !wr_data[`RC_POR])
				por_flag_ff <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// *** tb/deep_sleep_checker_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module deep_sleep_checker (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Observed ports
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic sleep_instr,
	input wire logic pin_change_evt,
	input wire logic fault_evt,
	input wire logic alarm_evt,
	input wire logic secondary_oscillator_tick,
	input wire logic low_power_rc_osc_tick,
	input wire logic in_deep_sleep,
	input wire logic wake_pulse,
	input wire logic calendar_clock_tick,
	input wire logic release_hold
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_entry_by_instr: assert property ($rose(in_deep_sleep) |-> $past(sleep_instr))
		else $error("sleep entered without instruction");
	a_pin_wakes: assert property (in_deep_sleep && pin_change_evt |=> !in_deep_sleep && wake_pulse)
		else $error("pin change did not wake");
	a_fault_wakes: assert property (in_deep_sleep && fault_evt |=> !in_deep_sleep && wake_pulse)
		else $error("fault did not wake");
	a_alarm_wakes: assert property (in_deep_sleep && alarm_evt |=> !in_deep_sleep && wake_pulse)
		else $error("alarm did not wake");
	a_wake_exit: assert property (wake_pulse |-> release_hold && !in_deep_sleep && $past(in_deep_sleep))
		else $error("wake pulse without exit");
	a_pulse_single: assert property (wake_pulse |=> !wake_pulse)
		else $error("wake pulse too long");
	a_cal_tick_src: assert property (calendar_clock_tick |-> $past(secondary_oscillator_tick) || $past(low_power_rc_osc_tick))
		else $error("calendar tick without source");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	c_entry: cover property ($rose(in_deep_sleep));
	c_wake: cover property (wake_pulse);
	c_cal: cover property (calendar_clock_tick);
endmodule
bind deep_sleep_wake_control deep_sleep_checker u_deep_sleep_checker (.aclk, .aresetn,
	.s_axi_bvalid, .s_axi_bready, .sleep_instr, .pin_change_evt, .fault_evt, .alarm_evt,
	.secondary_oscillator_tick, .low_power_rc_osc_tick, .in_deep_sleep, .wake_pulse,
	.calendar_clock_tick, .release_hold);
`default_nettype wire

// *** tb/wake_source_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module wake_source_model (
	// Clock and command
	input wire logic aclk,
	input wire logic [2:0] fire,
	input wire logic secondary_oscillator_req,
	input wire logic low_power_rc_osc_req,
	// Wake sources
	output logic pin_change_evt,
	output logic fault_evt,
	output logic alarm_evt,
	output logic master_reset_pin_n,
	// Oscillators
	output var logic secondary_oscillator_tick = 1'b0,
	output var logic low_power_rc_osc_tick = 1'b0,
	output var logic secondary_oscillator_on = 1'b1,
	output var logic low_power_rc_osc_on = 1'b0
);
	logic [1:0] div_ff = 2'h0;
	assign pin_change_evt = (fire == 3'h1);
	assign fault_evt = (fire == 3'h2);
	assign alarm_evt = (fire == 3'h3);
	assign master_reset_pin_n = (fire != 3'h4);
	// RC oscillator starts only when asked, one edge late; secondary oscillator starts on
	always @(posedge aclk) begin
		div_ff <= div_ff + 2'h1;
		if (secondary_oscillator_req) secondary_oscillator_on <= 1'b1;
		if (low_power_rc_osc_req) low_power_rc_osc_on <= 1'b1;
		secondary_oscillator_tick <= secondary_oscillator_on && div_ff == 2'h0;
		low_power_rc_osc_tick <= low_power_rc_osc_on && div_ff == 2'h2;
	end
endmodule
`default_nettype wire

// *** tb/deep_sleep_wake_control_test.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
	$display("BAD %0t mismatch %h expected %h", $time, got, exp); end end
module deep_sleep_wake_control_test;
	logic aclk = 1'b0, aresetn = 1'b0, true_power_on = 1'b0, sleep_instr = 1'b0;
	logic master_reset_pin_en = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic supply_por_evt = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, rd_d;
	logic [2:0] fire = 3'h0;
	logic [1:0] rd_r;
	int n_fail = 0, num_checks = 0;
	wire s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire pin_change_evt, fault_evt, alarm_evt, master_reset_pin_n, in_deep_sleep, wake_pulse;
	wire secondary_oscillator_tick, low_power_rc_osc_tick, secondary_oscillator_on;
	wire low_power_rc_osc_on, secondary_oscillator_req, low_power_rc_osc_req;
	wire calendar_clock_tick, release_hold;
	deep_sleep_wake_control u_deep_sleep_wake_control (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .true_power_on, .sleep_instr, .pin_change_evt, .fault_evt, .alarm_evt,
		.master_reset_pin_en, .master_reset_pin_n, .supply_por_evt,
		.secondary_oscillator_tick, .low_power_rc_osc_tick, .secondary_oscillator_on,
		.low_power_rc_osc_on, .in_deep_sleep, .wake_pulse, .secondary_oscillator_req,
		.low_power_rc_osc_req, .calendar_clock_tick, .release_hold);
	wake_source_model u_wake_source_model (.aclk, .fire, .secondary_oscillator_req,
		.low_power_rc_osc_req, .pin_change_evt, .fault_evt, .alarm_evt, .master_reset_pin_n,
		.secondary_oscillator_tick, .low_power_rc_osc_tick, .secondary_oscillator_on,
		.low_power_rc_osc_on);
	initial forever #10 aclk = ~aclk;
	task automatic complete_run;
		if (n_fail == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
		end while (!s_axi_bvalid && n < 50);
		s_axi_bready <= 1'b0;
		if (n >= 50) n_fail++;
	endtask
	task automatic rd(input logic [3:0] a);
		int n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
		end while (!s_axi_rvalid && n < 50);
		rd_d = s_axi_rdata;
		rd_r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 50) n_fail++;
	endtask
	// Arm, sleep, optionally try a blocked reset pin, then wake
	task automatic wake_by(input logic [2:0] f, input logic [15:0] exp, input logic blocked);
		int n = 0;
		wr(4'h0, 32'h0000_8000);
		@(posedge aclk);
		sleep_instr <= 1'b1;
		@(posedge aclk);
		sleep_instr <= 1'b0;
		@(posedge aclk);
		`CHK(in_deep_sleep, 1'b1)
		rd(4'h8);
		`CHK(rd_d[10], 1'b1)
		if (blocked) begin
			fire <= 3'h4;
			repeat (10) @(posedge aclk);
			`CHK(in_deep_sleep, 1'b1)
		end
		fire <= f;
		while (in_deep_sleep && n < 400) begin
			@(posedge aclk);
			n++;
		end
		fire <= 3'h0;
		`CHK(release_hold, 1'b1)
		rd(4'h4);
		`CHK(rd_d[15:0], exp)
		rd(4'h0);
		`CHK(rd_d[15], 1'b0)
		wr(4'h8, 32'h0);
		rd(4'h8);
		`CHK(rd_d[15:0], 16'h0000)
		wr(4'h0, 32'h0);
		`CHK(release_hold, 1'b0)
	endtask
	initial begin
		#200000;
		n_fail++;
		complete_run;
	end
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(4'hC);
		`CHK(rd_d[7:0], 8'h8F)
		rd(4'h8);
		`CHK(rd_d[15:0], 16'h0001)
		rd(4'h2);
		`CHK(rd_r, 2'h2)
		master_reset_pin_en <= 1'b1;
		wr(4'hC, 32'h0);
		wake_by(3'h1, 16'h0100, 1'b0);
		wake_by(3'h2, 16'h0080, 1'b0);
		wake_by(3'h3, 16'h0008, 1'b0);
		wake_by(3'h4, 16'h0004, 1'b0);
		master_reset_pin_en <= 1'b0;
		wake_by(3'h1, 16'h0100, 1'b1);
		wr(4'hC, 32'h0000_0080);
		wake_by(3'h0, 16'h0010, 1'b0);
		`CHK(low_power_rc_osc_on, 1'b1)
		wr(4'h4, 32'h0000_FFFF);
		rd(4'h4);
		`CHK(rd_d[15:0], 16'h0010)
		wr(4'h4, 32'h0);
		rd(4'h4);
		`CHK(rd_d[15:0], 16'h0000)
		true_power_on <= 1'b1;
		@(posedge aclk);
		true_power_on <= 1'b0;
		rd(4'h8);
		`CHK(rd_d[15:0], 16'h0001)
		rd(4'h4);
		`CHK(rd_d[15:0], 16'h0001)
		rd(4'hC);
		`CHK(rd_d[7:0], 8'h8F)
		wr(4'h4, 32'h0);
		rd(4'h4);
		`CHK(rd_d[15:0], 16'h0000)
		supply_por_evt <= 1'b1;
		@(posedge aclk);
		supply_por_evt <= 1'b0;
		rd(4'h4);
		`CHK(rd_d[15:0], 16'h0001)
		complete_run;
	end
endmodule
`default_nettype wire
